//--- core/port_pin_pkg.sv
package port_pin_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int CFG_W = 13;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SECOND_PORT = 6'h01;
  localparam logic [IDX_W-1:0] IDX_UPPER_DATA = 6'h10;
  localparam logic [IDX_W-1:0] IDX_UPPER_DIR = 6'h11;
  localparam logic [IDX_W-1:0] IDX_CONFIG = 6'h12;

  // Upper port A bits sit at positions 7:5 of their registers
  localparam int UPPER_LSB = 5;
  localparam int UPPER_N = 3;
  localparam int PIN_ANALOG = 0;
  localparam int PIN_CARRIER = 1;
  localparam int PIN_PLAIN = 2;

  // Configuration register fields
  localparam int CFG_OPTION_MAP = 0;
  localparam int CFG_PB_GP_LOW = 1;
  localparam int CFG_PB_GP_HIGH = 2;
  localparam int CFG_PA_OPEN_DRAIN = 3;
  localparam int CFG_PA_UPPER_OPEN_DRAIN = 4;
  localparam int CFG_PA_UPPER_PULLUP = 5;
  localparam int CFG_CARRIER_FUNCTION = 6;
  localparam int CFG_CARRIER_ON = 7;
  localparam int CFG_CARRIER_POLARITY = 8;
  localparam int CFG_PB_OD_LOW = 9;
  localparam int CFG_PB_OD_HIGH = 10;
  localparam int CFG_PB_PULLUP_LOW = 11;
  localparam int CFG_PB_PULLUP_HIGH = 12;

  // Converter channel that claims the analog-capable pin
  localparam logic [2:0] ANALOG_PIN_CHANNEL = 3'h1;

  // Values after reset
  localparam logic [CFG_W-1:0] CFG_RESET = 13'h0000;
  localparam logic [7:0] SECOND_DIR_RESET = 8'h00;
  localparam logic [UPPER_N-1:0] UPPER_DIR_RESET = 3'h0;
  localparam logic [7:0] FRONTPLANE_RESET = 8'hff;

  // Responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- core/pin_sync2.sv
`timescale 1ns/100ps
module pin_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

//--- core/port_pin_control.sv
// Overview of operation
// - Upper port A input pin: data write only updates latch; reads return pin level, except the analog pin, which reads 0 while the converter claims it.
// - Carrier open-drain without pullup: pin alternates driven low and high impedance.
// - Carrier open-drain with pullup: pin alternates driven low and pulled high.
// - Port B has eight bidirectional pins shared with frontplane segment outputs.
// - Port B data register decodes at index 1 of the normal map.
// - Port B direction register decodes at index 1 only in the option map.
// - Reset clears port B direction, so all pins start as inputs.
// - Reset leaves the port B data register untouched.
// - Frontplane function owns port B after reset until software releases it.
// - Port B output pin drives its data register bit.
// - Port B input pin: data read returns the sampled pin level under general-purpose control; pins the frontplane owns read 0.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module port_pin_control (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // AXI4-Lite write address
  input wire logic [port_pin_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data and response
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [port_pin_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Converter and carrier generator
  input wire logic CONV_POWER_ON,
  input wire logic [2:0] CONV_CHANNEL_SELECT,
  input wire logic CARRIER_PULSE,
  // Upper port A pins: bit 0 analog, bit 1 carrier, bit 2 plain
  input wire logic [port_pin_pkg::UPPER_N-1:0] UPPER_PIN_IN,
  output logic [port_pin_pkg::UPPER_N-1:0] UPPER_PIN_OUT,
  output logic [port_pin_pkg::UPPER_N-1:0] UPPER_PIN_OE,
  output logic [port_pin_pkg::UPPER_N-1:0] UPPER_PIN_PULLUP,
  output logic ANALOG_PIN_SELECT,
  // Port B pins and frontplane segments
  input wire logic [7:0] SECOND_PORT_IN,
  input wire logic [7:0] SEGMENT_DRIVE,
  output logic [7:0] SECOND_PORT_OUT,
  output logic [7:0] SECOND_PORT_OE,
  output logic [7:0] SECOND_PORT_PULLUP,
  output logic [7:0] FRONTPLANE_SELECT
);

  localparam int UN = port_pin_pkg::UPPER_N;
  localparam int UL = port_pin_pkg::UPPER_LSB;

  // Reset release
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  // Pin levels arrive from outside the clock domain
  logic [UN+7:0] pin_sync;
  logic [UN-1:0] upper_pin;
  logic [7:0] second_pin;

  pin_sync2 #(.W(UN + 8)) u_pin_sync (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .d({SECOND_PORT_IN, UPPER_PIN_IN}),
    .q(pin_sync)
  );

  assign upper_pin = pin_sync[UN-1:0];
  assign second_pin = pin_sync[UN+7:UN];

  // Register state
  logic [port_pin_pkg::CFG_W-1:0] cfg_r, cfg_nxt;
  logic [7:0] second_port_direction_r, second_port_direction_nxt;
  logic [7:0] second_port_data_r, second_port_data_nxt;
  logic [UN-1:0] upper_dir_r, upper_dir_nxt;
  logic [UN-1:0] output_latch_r, output_latch_nxt;

  // Bus state
  logic aw_held_r, aw_held_nxt;
  logic [port_pin_pkg::ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic w_held_r, w_held_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  // Derived controls
  logic option_map;
  logic analog_mode;
  logic [7:0] second_gp;
  logic [7:0] second_od;
  logic [7:0] second_pu;
  logic [7:0] second_read;
  logic [UN-1:0] upper_read;

  assign option_map = cfg_r[port_pin_pkg::CFG_OPTION_MAP];
  assign analog_mode = !upper_dir_r[port_pin_pkg::PIN_ANALOG] && CONV_POWER_ON &&
                       (CONV_CHANNEL_SELECT == port_pin_pkg::ANALOG_PIN_CHANNEL);

  // Returns {out, oe, pullup}; open drain only ever drives low
  function automatic logic [2:0] pin_drive(input logic dir, input logic val,
                                           input logic od, input logic pu_sel);
    logic [2:0] r;
    r = {1'b0, 1'b0, pu_sel};
    if (dir) begin
      if (od) begin
        r = {1'b0, !val, val && pu_sel};
      end else begin
        r = {val, 1'b1, 1'b0};
      end
    end
    return r;
  endfunction

  // Upper port A readback
  always_comb begin
    for (int i = 0; i < UN; i++) begin
      upper_read[i] = upper_dir_r[i] ? output_latch_r[i] : upper_pin[i];
    end
    if (analog_mode) begin
      upper_read[port_pin_pkg::PIN_ANALOG] = 1'b0;
    end
  end

  // Port B pin control and readback, one slice per pin
  logic [7:0] second_out_nxt, second_oe_nxt, second_pu_nxt;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_second
      localparam bit HIGH = (g >= 4);
      logic [2:0] drv;
      assign second_gp[g] = HIGH ? cfg_r[port_pin_pkg::CFG_PB_GP_HIGH]
                                 : cfg_r[port_pin_pkg::CFG_PB_GP_LOW];
      assign second_od[g] = HIGH ? cfg_r[port_pin_pkg::CFG_PB_OD_HIGH]
                                 : cfg_r[port_pin_pkg::CFG_PB_OD_LOW];
      assign second_pu[g] = HIGH ? cfg_r[port_pin_pkg::CFG_PB_PULLUP_HIGH]
                                 : cfg_r[port_pin_pkg::CFG_PB_PULLUP_LOW];
      assign drv = pin_drive(second_port_direction_r[g], second_port_data_r[g],
                             second_od[g], second_pu[g]);
      assign second_out_nxt[g] = second_gp[g] ? drv[2] : SEGMENT_DRIVE[g];
      assign second_oe_nxt[g] = second_gp[g] ? drv[1] : 1'b1;
      // Pullup under a frontplane pin loads the segment; software must avoid it
      assign second_pu_nxt[g] = second_gp[g] ? drv[0] : second_pu[g];
      assign second_read[g] = !second_gp[g] ? 1'b0 :
                              second_port_direction_r[g] ? second_port_data_r[g] :
                              second_pin[g];
    end
  endgenerate

  // Upper port A pin control
  logic [UN-1:0] upper_out_nxt, upper_oe_nxt, upper_pu_nxt;
  logic analog_sel_nxt;

  always_comb begin
    logic [2:0] drv;
    logic carrier_val;
    logic carrier_od;
    logic pu_sel;
    logic pa_od;
    drv = 3'h0;
    carrier_val = 1'b0;
    carrier_od = 1'b0;
    pu_sel = cfg_r[port_pin_pkg::CFG_PA_UPPER_PULLUP];
    pa_od = cfg_r[port_pin_pkg::CFG_PA_OPEN_DRAIN];

    drv = pin_drive(upper_dir_r[port_pin_pkg::PIN_ANALOG],
                    output_latch_r[port_pin_pkg::PIN_ANALOG], pa_od, pu_sel);
    if (analog_mode) begin
      drv = 3'h0;
    end
    {upper_out_nxt[0], upper_oe_nxt[0], upper_pu_nxt[0]} = drv;
    analog_sel_nxt = analog_mode;

    if (cfg_r[port_pin_pkg::CFG_CARRIER_FUNCTION]) begin
      if (cfg_r[port_pin_pkg::CFG_CARRIER_ON]) begin
        carrier_val = CARRIER_PULSE;
        carrier_od = pa_od;
      end else begin
        carrier_val = cfg_r[port_pin_pkg::CFG_CARRIER_POLARITY];
        carrier_od = 1'b0;
      end
    end else begin
      carrier_val = output_latch_r[port_pin_pkg::PIN_CARRIER];
      carrier_od = pa_od;
    end
    drv = pin_drive(upper_dir_r[port_pin_pkg::PIN_CARRIER], carrier_val, carrier_od, pu_sel);
    {upper_out_nxt[1], upper_oe_nxt[1], upper_pu_nxt[1]} = drv;

    drv = pin_drive(upper_dir_r[port_pin_pkg::PIN_PLAIN],
                    output_latch_r[port_pin_pkg::PIN_PLAIN],
                    cfg_r[port_pin_pkg::CFG_PA_UPPER_OPEN_DRAIN], pu_sel);
    {upper_out_nxt[2], upper_oe_nxt[2], upper_pu_nxt[2]} = drv;
  end

  // Pin outputs come straight from flip-flops
  logic [UN-1:0] upper_out_r, upper_oe_r, upper_pu_r;
  logic analog_sel_r;
  logic [7:0] second_out_r, second_oe_r, second_pu_r, frontplane_r;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      upper_out_r <= '0;
      upper_oe_r <= '0;
      upper_pu_r <= '0;
      analog_sel_r <= 1'b0;
      second_out_r <= 8'h00;
      second_oe_r <= 8'h00;
      second_pu_r <= 8'h00;
      frontplane_r <= port_pin_pkg::FRONTPLANE_RESET;
    end else begin
      upper_out_r <= upper_out_nxt;
      upper_oe_r <= upper_oe_nxt;
      upper_pu_r <= upper_pu_nxt;
      analog_sel_r <= analog_sel_nxt;
      second_out_r <= second_out_nxt;
      second_oe_r <= second_oe_nxt;
      second_pu_r <= second_pu_nxt;
      frontplane_r <= ~second_gp;
    end
  end

  // Bus slave and register writes
  always_comb begin
    logic [port_pin_pkg::IDX_W-1:0] widx;
    logic [port_pin_pkg::IDX_W-1:0] ridx;
    logic whit;
    widx = aw_addr_r[port_pin_pkg::ADDR_W-1:2];
    ridx = ARADDR[port_pin_pkg::ADDR_W-1:2];
    whit = 1'b0;
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    cfg_nxt = cfg_r;
    second_port_direction_nxt = second_port_direction_r;
    second_port_data_nxt = second_port_data_r;
    upper_dir_nxt = upper_dir_r;
    output_latch_nxt = output_latch_r;

    if (AWVALID && awready_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = AWADDR;
    end
    if (WVALID && wready_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = WDATA;
      w_strb_nxt = WSTRB;
    end
    if (bvalid_r && BREADY) begin
      bvalid_nxt = 1'b0;
    end
    // Address and data both present: commit and answer next edge
    if (aw_held_r && w_held_r && !bvalid_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      whit = 1'b1;
      case (widx)
        port_pin_pkg::IDX_SECOND_PORT: begin
          if (w_strb_r[0] && option_map) begin
            second_port_direction_nxt = w_data_r[7:0];
          end else if (w_strb_r[0]) begin
            second_port_data_nxt = w_data_r[7:0];
          end
        end
        port_pin_pkg::IDX_UPPER_DATA: begin
          if (w_strb_r[0]) begin
            output_latch_nxt = w_data_r[UL+UN-1:UL];
          end
        end
        port_pin_pkg::IDX_UPPER_DIR: begin
          if (w_strb_r[0]) begin
            upper_dir_nxt = w_data_r[UL+UN-1:UL];
          end
        end
        port_pin_pkg::IDX_CONFIG: begin
          if (w_strb_r[0]) begin
            cfg_nxt[7:0] = w_data_r[7:0];
          end
          if (w_strb_r[1]) begin
            cfg_nxt[port_pin_pkg::CFG_W-1:8] = w_data_r[port_pin_pkg::CFG_W-1:8];
          end
        end
        default: begin
          whit = 1'b0;
        end
      endcase
      bresp_nxt = whit ? port_pin_pkg::RESP_OKAY : port_pin_pkg::RESP_SLVERR;
    end

    if (rvalid_r && RREADY) begin
      rvalid_nxt = 1'b0;
    end
    if (ARVALID && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = port_pin_pkg::RESP_OKAY;
      rdata_nxt = 32'h0;
      case (ridx)
        port_pin_pkg::IDX_SECOND_PORT: begin
          rdata_nxt[7:0] = option_map ? second_port_direction_r : second_read;
        end
        port_pin_pkg::IDX_UPPER_DATA: begin
          rdata_nxt[UL+UN-1:UL] = upper_read;
        end
        port_pin_pkg::IDX_UPPER_DIR: begin
          rdata_nxt[UL+UN-1:UL] = upper_dir_r;
        end
        port_pin_pkg::IDX_CONFIG: begin
          rdata_nxt[port_pin_pkg::CFG_W-1:0] = cfg_r;
        end
        default: begin
          rresp_nxt = port_pin_pkg::RESP_SLVERR;
        end
      endcase
    end

    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt = !w_held_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
      cfg_r <= port_pin_pkg::CFG_RESET;
      second_port_direction_r <= port_pin_pkg::SECOND_DIR_RESET;
      upper_dir_r <= port_pin_pkg::UPPER_DIR_RESET;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      cfg_r <= cfg_nxt;
      second_port_direction_r <= second_port_direction_nxt;
      upper_dir_r <= upper_dir_nxt;
    end
  end

  // Data latches keep their contents through reset
  always_ff @(posedge CLK_SYS) begin
    second_port_data_r <= second_port_data_nxt;
    output_latch_r <= output_latch_nxt;
  end

  assign AWREADY = awready_r;
  assign WREADY = wready_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign UPPER_PIN_OUT = upper_out_r;
  assign UPPER_PIN_OE = upper_oe_r;
  assign UPPER_PIN_PULLUP = upper_pu_r;
  assign ANALOG_PIN_SELECT = analog_sel_r;
  assign SECOND_PORT_OUT = second_out_r;
  assign SECOND_PORT_OE = second_oe_r;
  assign SECOND_PORT_PULLUP = second_pu_r;
  assign FRONTPLANE_SELECT = frontplane_r;

endmodule

//--- bench/port_pin_control_assertions.sv
`timescale 1ns/100ps
module port_pin_checker (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Register bus handshakes
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  // Converter
  input wire logic CONV_POWER_ON,
  input wire logic [2:0] CONV_CHANNEL_SELECT,
  input wire logic ANALOG_PIN_SELECT,
  input wire logic [port_pin_pkg::UPPER_N-1:0] UPPER_PIN_OE,
  input wire logic [port_pin_pkg::UPPER_N-1:0] UPPER_PIN_PULLUP,
  // Port B and frontplane
  input wire logic [7:0] SEGMENT_DRIVE,
  input wire logic [7:0] SECOND_PORT_OUT,
  input wire logic [7:0] SECOND_PORT_OE,
  input wire logic [7:0] FRONTPLANE_SELECT
);
  // Internal reset trails the pin, so pin relations wait until it has surely released
  logic [2:0] up_r;
  logic [2:0] up_nxt;
  always_comb begin
    up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
  end
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) up_r <= 3'h0;
    else up_r <= up_nxt;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  sequence aw_w_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence ar_taken;
    ARVALID && ARREADY;
  endsequence
  fp_reset_a: assert property ($rose(RST_B) |-> (FRONTPLANE_SELECT == 8'hff)[*3])
    else $error("frontplane not selected after reset");
  fp_drive_a: assert property (up_r == 3'h7 |-> ((SECOND_PORT_OUT ^ $past(SEGMENT_DRIVE))
    & FRONTPLANE_SELECT & $past(FRONTPLANE_SELECT)) == 8'h0)
    else $error("frontplane pin not driven by segment value");
  fp_oe_a: assert property (up_r == 3'h7 |-> (FRONTPLANE_SELECT & ~SECOND_PORT_OE) == 8'h0)
    else $error("frontplane pin not enabled");
  analog_cause_a: assert property (up_r == 3'h7 && ANALOG_PIN_SELECT |-> $past(CONV_POWER_ON)
    && $past(CONV_CHANNEL_SELECT) == port_pin_pkg::ANALOG_PIN_CHANNEL)
    else $error("analog pin taken without converter channel");
  analog_float_a: assert property (ANALOG_PIN_SELECT |-> !UPPER_PIN_OE[0] && !UPPER_PIN_PULLUP[0])
    else $error("analog pin still driven");
  wr_answer_a: assert property (aw_w_taken |=> ##1 BVALID)
    else $error("write response late");
  wr_close_a: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
    else $error("write channel not reopened");
  rd_answer_a: assert property (ar_taken |=> RVALID && !ARREADY)
    else $error("read answer late");
  rd_close_a: assert property (RVALID && RREADY |=> !RVALID && ARREADY)
    else $error("read channel not reopened");
endmodule
bind port_pin_control port_pin_checker port_pin_checker_inst (.CLK_SYS, .RST_B, .AWVALID,
  .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .ARVALID, .ARREADY, .RVALID, .RREADY,
  .CONV_POWER_ON, .CONV_CHANNEL_SELECT, .ANALOG_PIN_SELECT, .UPPER_PIN_OE, .UPPER_PIN_PULLUP,
  .SEGMENT_DRIVE, .SECOND_PORT_OUT, .SECOND_PORT_OE, .FRONTPLANE_SELECT);

//--- bench/tb_port_pin_control.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_port_pin_control;
  logic CLK_SYS, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, CONV_POWER_ON;
  logic CARRIER_PULSE, AWREADY, WREADY, BVALID, ARREADY, RVALID, ANALOG_PIN_SELECT;
  logic [7:0] AWADDR, ARADDR, SECOND_PORT_IN, SEGMENT_DRIVE;
  logic [7:0] SECOND_PORT_OUT, SECOND_PORT_OE, SECOND_PORT_PULLUP, FRONTPLANE_SELECT;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, eb;
  logic [2:0] CONV_CHANNEL_SELECT, UPPER_PIN_IN, UPPER_PIN_OUT, UPPER_PIN_OE, UPPER_PIN_PULLUP;
  logic [33:0] er;
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  int err_total, total_checks;
  localparam logic [7:0] A_PB = {port_pin_pkg::IDX_SECOND_PORT, 2'h0};
  localparam logic [7:0] A_UD = {port_pin_pkg::IDX_UPPER_DATA, 2'h0};
  localparam logic [7:0] A_UR = {port_pin_pkg::IDX_UPPER_DIR, 2'h0};
  localparam logic [7:0] A_CF = {port_pin_pkg::IDX_CONFIG, 2'h0};
  localparam logic [1:0] rs_ok = port_pin_pkg::RESP_OKAY;
  localparam logic [1:0] rs_err = port_pin_pkg::RESP_SLVERR;
  port_pin_control port_pin_control_inst (.*);
  always #2 CLK_SYS = ~CLK_SYS;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > 200) begin
      err_total++;
      $display("FAIL bus wait exp 1 got 0");
      complete_run();
    end
  endtask
  // Ready lines stay high throughout, so every response is taken where it appears
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    int n;
    logic aw, w;
    n = 0;
    aw = 0;
    w = 0;
    wq.push_back(r);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    while (!(aw && w)) begin
      @(posedge CLK_SYS);
      guard(n);
      if (AWVALID && AWREADY) begin aw = 1; AWVALID <= 1'h0; end
      if (WVALID && WREADY) begin w = 1; WVALID <= 1'h0; end
    end
    do begin @(posedge CLK_SYS); guard(n); end while (!BVALID);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    int n;
    n = 0;
    rq.push_back({r, d});
    ARADDR <= a;
    ARVALID <= 1'h1;
    do begin @(posedge CLK_SYS); guard(n); end while (!ARREADY);
    ARVALID <= 1'h0;
    do begin @(posedge CLK_SYS); guard(n); end while (!RVALID);
  endtask
  task automatic do_reset();
    RST_B <= 1'h0;
    repeat (16) @(posedge CLK_SYS);
    RST_B <= 1'h1;
    SEGMENT_DRIVE <= $urandom;
    repeat (4) @(posedge CLK_SYS);
  endtask
  always @(posedge CLK_SYS) begin
    if (BVALID && BREADY) begin
      eb = wq.pop_front();
      `CHK("bresp", eb, BRESP)
    end
    if (RVALID && RREADY) begin
      er = rq.pop_front();
      `CHK("rdata", er, {RRESP, RDATA})
    end
  end
  initial begin
    logic [7:0] d, m, p;
    logic [2:0] l, u;
    logic po;
    {CLK_SYS, RST_B, AWVALID, WVALID, ARVALID, CONV_POWER_ON, CARRIER_PULSE} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB, CONV_CHANNEL_SELECT} = '0;
    {BREADY, RREADY} = 2'h3;
    err_total = 0;
    total_checks = 0;
    void'($urandom(80));
    SEGMENT_DRIVE = $urandom;
    SECOND_PORT_IN = $urandom;
    UPPER_PIN_IN = $urandom;
    do_reset();
    `CHK("fp_sel", 8'hff, FRONTPLANE_SELECT)
    `CHK("fp_out", SEGMENT_DRIVE, SECOND_PORT_OUT)
    rd(A_PB, rs_ok, 32'h0);
    d = $urandom;
    wr(A_PB, {24'h0, d}, 4'h1, rs_ok);
    do_reset();
    wr(A_CF, 32'h7, 4'h3, rs_ok);
    rd(A_PB, rs_ok, 32'h0);
    wr(A_PB, 32'hff, 4'h1, rs_ok);
    rd(A_PB, rs_ok, 32'hff);
    wr(A_CF, 32'h6, 4'h3, rs_ok);
    repeat (2) @(posedge CLK_SYS);
    `CHK("fp_off", 8'h0, FRONTPLANE_SELECT)
    `CHK("kept", d, SECOND_PORT_OUT)
    $display("test reset done");
    repeat (4) begin
      d = $urandom;
      m = $urandom;
      p = $urandom;
      SECOND_PORT_IN <= p;
      wr(A_PB, {24'h0, d}, 4'h1, rs_ok);
      wr(A_PB, {24'h0, ~d}, 4'h0, rs_ok);
      wr(A_CF, 32'h7, 4'h3, rs_ok);
      wr(A_PB, {24'h0, m}, 4'h1, rs_ok);
      wr(A_CF, 32'h6, 4'h3, rs_ok);
      rd(A_PB, rs_ok, {24'h0, (d & m) | (p & ~m)});
      `CHK("pb_oe", m, SECOND_PORT_OE)
      `CHK("pb_out", d & m, SECOND_PORT_OUT & m)
    end
    wr(A_CF, 32'h1e06, 4'h3, rs_ok);
    repeat (2) @(posedge CLK_SYS);
    `CHK("pb_od_oe", m & ~d, SECOND_PORT_OE)
    `CHK("pb_pu", ~m | d, SECOND_PORT_PULLUP)
    wr(A_CF, 32'h6, 4'h3, rs_ok);
    wr(8'h3c, $urandom, 4'hf, rs_err);
    rd(8'h3c, rs_err, 32'h0);
    $display("test port b done");
    l = $urandom;
    u = $urandom;
    UPPER_PIN_IN <= u;
    wr(A_UR, 32'h0, 4'h1, rs_ok);
    wr(A_UD, {24'h0, l, 5'h0}, 4'h1, rs_ok);
    `CHK("up_oe", 3'h0, UPPER_PIN_OE)
    rd(A_UD, rs_ok, {24'h0, u, 5'h0});
    CONV_POWER_ON <= 1'h1;
    for (int c = 0; c < 8; c++) begin
      CONV_CHANNEL_SELECT <= c[2:0];
      repeat (3) @(posedge CLK_SYS);
      `CHK("an_sel", c == 1, ANALOG_PIN_SELECT)
      if (c == 1) rd(A_UD, rs_ok, {24'h0, u & 3'h6, 5'h0});
    end
    CONV_POWER_ON <= 1'h0;
    wr(A_UR, 32'he0, 4'h1, rs_ok);
    // Pin outputs trail the register edge by one clock
    @(posedge CLK_SYS);
    `CHK("up_drv", {3'h7, l}, {UPPER_PIN_OE, UPPER_PIN_OUT})
    rd(A_UD, rs_ok, {24'h0, l, 5'h0});
    $display("test upper pins done");
    wr(A_UR, 32'h40, 4'h1, rs_ok);
    for (int pol = 0; pol < 2; pol++) begin
      wr(A_CF, 32'h46 | (pol << 8), 4'h3, rs_ok);
      @(posedge CLK_SYS);
      `CHK("idle", {1'h1, pol[0]}, {UPPER_PIN_OE[1], UPPER_PIN_OUT[1]})
    end
    for (int pu = 0; pu < 2; pu++) begin
      wr(A_CF, 32'hce | (pu << 5), 4'h3, rs_ok);
      po = CARRIER_PULSE;
      repeat (16) begin
        @(posedge CLK_SYS);
        `CHK("carr_oe", ~po, UPPER_PIN_OE[1])
        `CHK("carr_lvl", po & pu[0], po ? UPPER_PIN_PULLUP[1] : UPPER_PIN_OUT[1])
        po = CARRIER_PULSE;
        CARRIER_PULSE <= $urandom;
      end
    end
    $display("test carrier done");
    complete_run();
  end
endmodule
